// file: design/acc_cal_regs.sv
// Purpose: axi4-lite register bank steering the adc calibration engine
// Assumes: one clock, synchronous active-low reset
// Notes: foreground run length is a parameter standing in for the engine
`timescale 1ns/10ps
`include "acc_cfg.svh"

module acc_cal_regs #(
   parameter int FG_CYCLES = 64
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cal_run,
   output logic divider_reset,
   output logic fg_reset_values,
   output logic fg_active,
   output logic background_trim_enable,
   output logic background_offset_trim_enable,
   output logic foreground_offset_trim_enable,
   output logic offset_reference_select,
   output logic [2:0] offset_averaging_depth,
   output logic [2:0] linearity_averaging_depth,
   output logic foreground_trim_complete
);

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   logic [7:0] run_reg;
   logic [7:0] mode_reg;
   logic [7:0] oref_reg;
   logic [7:0] avg_reg;
   logic aw_held_reg;
   logic [9:0] aw_idx_reg;
   logic w_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   // ----------------------------------------------------------------
   // write handshake
   // ----------------------------------------------------------------
   // both channels stall while a response waits, so one write at a time
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;

   wire aw_have = aw_held_reg || aw_take;
   wire w_have = w_held_reg || w_take;
   wire do_write = aw_have && w_have && !bvalid_reg;
   wire [9:0] wr_idx = aw_held_reg ? aw_idx_reg : s_axi_awaddr[11:2];
   wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   wire wr_lane0 = do_write && wr_strb[0];
   wire [7:0] wr_byte = wr_data[7:0];

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   // only byte lane zero carries a register; other lanes are dropped
   wire wr_run_hit = wr_idx == {2'b00, `ACC_IDX_RUN};
   wire wr_mode_hit = wr_idx == {2'b00, `ACC_IDX_MODE};
   wire wr_oref_hit = wr_idx == {2'b00, `ACC_IDX_OREF};
   wire wr_avg_hit = wr_idx == {2'b00, `ACC_IDX_AVG};
   wire wr_stat_hit = wr_idx == {2'b00, `ACC_IDX_STAT};
   wire wr_mapped = wr_run_hit || wr_mode_hit || wr_oref_hit || wr_avg_hit
      || wr_stat_hit;

   // reserved bits are stored as written; host keeps them at default
   wire [7:0] run_next = (wr_lane0 && wr_run_hit) ? wr_byte : run_reg;
   wire [7:0] mode_next = (wr_lane0 && wr_mode_hit) ? wr_byte : mode_reg;
   wire [7:0] oref_next = (wr_lane0 && wr_oref_hit) ? wr_byte : oref_reg;
   wire [7:0] avg_next = (wr_lane0 && wr_avg_hit) ? wr_byte : avg_reg;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   // run enable resets high so calibration starts straight after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_reg <= `ACC_RST_RUN;
      end else begin
         run_reg <= run_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= `ACC_RST_MODE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oref_reg <= `ACC_RST_OREF;
      end else begin
         oref_reg <= oref_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         avg_reg <= `ACC_RST_AVG;
      end else begin
         avg_reg <= avg_next;
      end
   end

   // ----------------------------------------------------------------
   // write holding
   // ----------------------------------------------------------------
   // address and data may arrive on different edges; each side is
   // parked here until its partner shows up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_idx_reg <= 10'h000;
      end else if (aw_take) begin
         aw_idx_reg <= s_axi_awaddr[11:2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else if (w_take) begin
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
      end else begin
         aw_held_reg <= aw_have && !do_write;
         w_held_reg <= w_have && !do_write;
      end
   end

   // ----------------------------------------------------------------
   // write response
   // ----------------------------------------------------------------
   // unmapped words answer with an error; the status word ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `ACC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ----------------------------------------------------------------
   // calibration sequencing
   // ----------------------------------------------------------------
   acc_pkg::acc_state_t state_reg;
   acc_pkg::acc_state_t state_next;
   logic [15:0] fg_cnt_reg;
   logic run_d_reg;

   // the foreground run length stands in for the real engine
   localparam logic [15:0] FG_LAST = 16'(FG_CYCLES - 1);
   wire run_en = run_reg[`ACC_BIT_RUN];
   wire fg_sel = mode_reg[`ACC_BIT_FG];
   wire run_rise = run_en && !run_d_reg;
   wire fg_end = fg_cnt_reg == FG_LAST;

   // ----------------------------------------------------------------
   // sequencing state machine
   // ----------------------------------------------------------------
   // clearing run enable wins over every state and returns to idle
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         acc_pkg::ACC_IDLE: begin
            if (run_en) begin
               state_next = fg_sel ? acc_pkg::ACC_FG_RUN
                  : acc_pkg::ACC_DONE;
            end
         end
         acc_pkg::ACC_FG_RUN: begin
            if (fg_end) begin
               state_next = acc_pkg::ACC_DONE;
            end
         end
         acc_pkg::ACC_DONE: begin
            state_next = acc_pkg::ACC_DONE;
         end
         default: begin
            state_next = acc_pkg::ACC_IDLE;
         end
      endcase
      if (!run_en) begin
         state_next = acc_pkg::ACC_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= acc_pkg::ACC_IDLE;
         fg_cnt_reg <= 16'h0000;
         run_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         run_d_reg <= run_en;
         fg_cnt_reg <= (state_reg == acc_pkg::ACC_FG_RUN && !fg_end)
            ? fg_cnt_reg + 16'h0001 : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // foreground completion
   // ----------------------------------------------------------------
   // follows the next state so it rises on the edge that enters done
   logic done_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= state_next == acc_pkg::ACC_DONE;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the calibration engine
   // ----------------------------------------------------------------
   wire bg_sel = mode_reg[`ACC_BIT_BG];
   wire bgos_sel = mode_reg[`ACC_BIT_BGOS];
   wire fgos_sel = mode_reg[`ACC_BIT_OS];

   assign cal_run = run_en;
   assign divider_reset = !run_en;
   assign fg_reset_values = run_rise;
   assign fg_active = state_reg == acc_pkg::ACC_FG_RUN;
   assign background_trim_enable = run_en && bg_sel;
   assign background_offset_trim_enable = background_trim_enable
      && bgos_sel;
   assign foreground_offset_trim_enable = fg_active && fgos_sel;
   // zero: mid-code target, one: spare converter target
   assign offset_reference_select = oref_reg[`ACC_BIT_OFFSET_REFERENCE_SELECT];
   assign offset_averaging_depth =
      avg_reg[`ACC_OSAVG_HI:`ACC_OSAVG_LO];
   assign linearity_averaging_depth =
      avg_reg[`ACC_LAVG_HI:`ACC_LAVG_LO];
   assign foreground_trim_complete = done_reg;

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // a new read is refused until the previous answer has been taken
   assign s_axi_arready = !rvalid_reg;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [9:0] rd_idx = s_axi_araddr[11:2];
   wire rd_run = rd_idx == {2'b00, `ACC_IDX_RUN};
   wire rd_mode = rd_idx == {2'b00, `ACC_IDX_MODE};
   wire rd_oref = rd_idx == {2'b00, `ACC_IDX_OREF};
   wire rd_avg = rd_idx == {2'b00, `ACC_IDX_AVG};
   wire rd_stat = rd_idx == {2'b00, `ACC_IDX_STAT};
   wire rd_mapped = rd_run || rd_mode || rd_oref || rd_avg || rd_stat;
   wire [7:0] stat_byte = {7'h00, done_reg};
   wire [7:0] rd_byte = rd_run ? run_reg
      : rd_mode ? mode_reg
      : rd_oref ? oref_reg
      : rd_avg ? avg_reg
      : rd_stat ? stat_byte : 8'h00;

   // ----------------------------------------------------------------
   // read response
   // ----------------------------------------------------------------
   // data and response are registered so they stand until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `ACC_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_byte};
         rresp_reg <= rd_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

endmodule

// file: design/acc_cfg.svh
// Purpose: constants for the calibration control register bank
// Assumes: axi4-lite, 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is index * 4
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define ACC_IDX_RUN 8'h61
`define ACC_IDX_MODE 8'h62
`define ACC_IDX_OREF 8'h65
`define ACC_IDX_AVG 8'h68
`define ACC_IDX_STAT 8'h6a

`define ACC_RST_RUN 8'h01
`define ACC_RST_MODE 8'h01
`define ACC_RST_OREF 8'h01
`define ACC_RST_AVG 8'h61

`define ACC_BIT_RUN 0
`define ACC_BIT_FG 0
`define ACC_BIT_BG 1
`define ACC_BIT_OS 2
`define ACC_BIT_BGOS 3
`define ACC_BIT_OFFSET_REFERENCE_SELECT 2
`define ACC_OSAVG_HI 6
`define ACC_OSAVG_LO 4
`define ACC_LAVG_HI 2
`define ACC_LAVG_LO 0
`define ACC_BIT_DONE 0

`define ACC_RESP_OKAY 2'b00
`define ACC_RESP_SLVERR 2'b10

`endif

// file: design/acc_pkg.sv
// Purpose: types for the calibration control register bank
// Assumes: nothing
// Notes: constants live in acc_cfg.svh
package acc_pkg;
   typedef enum logic [1:0] {ACC_IDLE, ACC_FG_RUN, ACC_DONE} acc_state_t;
endpackage

// file: tb/acc_cal_regs_asserts.sv
// Purpose: port assertions for the calibration register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound into acc_cal_regs
`timescale 1ns/10ps
module acc_chk #(
   parameter int FG_CYCLES = 64
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic cal_run,
   input wire logic divider_reset,
   input wire logic fg_reset_values,
   input wire logic fg_active,
   input wire logic background_trim_enable,
   input wire logic background_offset_trim_enable,
   input wire logic foreground_offset_trim_enable,
   input wire logic foreground_trim_complete
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] act_reg;
   // counts the cycles of one foreground run
   always_ff @(posedge aclk) begin
      if (!aresetn || !fg_active) begin
         act_reg <= 16'h0000;
      end else begin
         act_reg <= act_reg + 16'h0001;
      end
   end
   AST_FGRST: assert property ($rose(cal_run) |-> fg_reset_values)
      else $error("values not reset on run start");
   AST_DIV: assert property (divider_reset == !cal_run)
      else $error("divider reset not inverse of run enable");
   AST_HOLD: assert property (!cal_run |=> !fg_active &&
      !foreground_trim_complete) else $error("calibration not held");
   AST_BG: assert property (background_trim_enable |-> cal_run)
      else $error("background on while held");
   AST_BGOS: assert property (background_offset_trim_enable
      |-> background_trim_enable) else $error("bg offset without bg");
   AST_FGOS: assert property (foreground_offset_trim_enable
      |-> fg_active) else $error("fg offset without fg run");
   AST_LEN: assert property ($fell(fg_active) && cal_run
      |-> act_reg == FG_CYCLES) else $error("fg run length wrong");
   AST_DONE: assert property ($fell(fg_active) && cal_run
      |-> foreground_trim_complete) else $error("complete missing");
   AST_RLAT: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   AST_RDROP: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read answer not released");
   AST_BDROP: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write answer not released");
endmodule

bind acc_cal_regs acc_chk #(.FG_CYCLES(FG_CYCLES)) acc_chk_i (.aclk,
   .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bready, .cal_run, .divider_reset,
   .fg_reset_values, .fg_active,
   .background_trim_enable, .background_offset_trim_enable,
   .foreground_offset_trim_enable, .foreground_trim_complete);

// file: tb/acc_tb.sv
// Purpose: register-level tests of the calibration register bank
// Assumes: FG_CYCLES shortened to 4; answers taken at the rising edge
// Notes: bready and rready are held high throughout
`timescale 1ns/10ps
`include "acc_cfg.svh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, cal_run, divider_reset;
   logic fg_reset_values, fg_active, background_trim_enable;
   logic background_offset_trim_enable, foreground_offset_trim_enable;
   logic offset_reference_select, foreground_trim_complete;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot, k;
   logic [2:0] offset_averaging_depth, linearity_averaging_depth;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int mismatches, tests_run, cyc;
   logic [11:0] adr [4] = '{12'h184, 12'h188, 12'h194, 12'h1a0};
   logic [7:0] rv [4] = '{`ACC_RST_RUN, `ACC_RST_MODE, `ACC_RST_OREF,
      `ACC_RST_AVG};
   logic [7:0] md [5] = '{8'h0d, 8'h0e, 8'h09, 8'h08, 8'h0f};
   logic [3:0] ex [5] = '{4'h3, 4'hc, 4'h2, 4'h0, 4'hf};
   acc_cal_regs #(.FG_CYCLES(4)) acc_cal_regs_i (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [35:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!b);
   endtask
   task automatic rdr(input logic [11:0] a);
      logic b;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         b = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!b);
   endtask
   task automatic waitc;
      for (int n = 0; n < 20 && foreground_trim_complete !== 1'b1; n++)
         @(negedge aclk);
      chk("done", {foreground_trim_complete, fg_active}, 2'b10);
      @(posedge aclk);
   endtask
   task automatic conclude;
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
      {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hf};
      {s_axi_bready, s_axi_rready} = 2'b11;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdr(adr[i]);
         chk("reset", {rs, rd}, {2'b00, 24'h0, rv[i]});
      end
      waitc;
      rdr(12'h1a8);
      chk("status", rd, 32'h1);
      for (int i = 0; i < 5; i++) begin
         wr(12'h184, 32'h0);
         chk("held", {cal_run, divider_reset}, 2'b01);
         rdr(12'h1a8);
         chk("cleared", rd, 32'h0);
         wr(12'h188, {24'h0, md[i]});
         wr(12'h184, 32'h1);
         @(negedge aclk);
         chk("mode", {background_trim_enable, background_offset_trim_enable,
            fg_active, foreground_offset_trim_enable}, ex[i]);
         waitc;
      end
      for (int j = 0; j < 2; j++) begin
         wr(12'h194, {29'h0, j[0], 2'b01});
         chk("oref", offset_reference_select, j[0]);
      end
      for (int i = 0; i < 8; i++) begin
         k = i[2:0];
         wr(12'h1a0, {25'h0, k, 1'b0, ~k});
         chk("avg", {offset_averaging_depth, linearity_averaging_depth},
            {k, ~k});
         rdr(12'h1a0);
         chk("avg read", rd, {25'h0, k, 1'b0, ~k});
      end
      rdr(12'h1a4);
      chk("unmapped", {rs, rd}, {`ACC_RESP_SLVERR, 32'h0});
      wr(12'h1a4, 32'h0);
      chk("wresp bad", rs, `ACC_RESP_SLVERR);
      wr(12'h1a8, 32'h0);
      chk("wresp ro", rs, `ACC_RESP_OKAY);
      rdr(12'h1a8);
      chk("status ro", {rs, rd}, {`ACC_RESP_OKAY, 32'h1});
      s_axi_wstrb <= 4'h0;
      wr(12'h188, 32'h0);
      s_axi_wstrb <= 4'hf;
      rdr(12'h188);
      chk("no strobe", rd, 32'h0f);
      conclude();
   end
endmodule
